/* File: qdr_defines.svh */
// constants of the quad converter readback link
`ifndef QDR_DEFINES_SVH
`define QDR_DEFINES_SVH
// slave address: fixed upper five bits, two pin bits, direction bit
`define QDR_SLAVE_BASE 5'h13
`define QDR_DIR_WRITE 1'b0
`define QDR_DIR_READ 1'b1
// fixed fill bits and bytes sent back by the device
`define QDR_PD_FILL 6'h3f
`define QDR_LOW_FILL 8'h00
// bits per byte before the acknowledge slot
`define QDR_ACK_SLOT 4'h8
// scl timing of the controller (fast mode, four quarters per bit)
`define QDR_CLK_PERIOD_NS 10
`define QDR_SCL_QUARTER_NS 625
`define QDR_SCL_QUARTER_CYCLES ((`QDR_SCL_QUARTER_NS + `QDR_CLK_PERIOD_NS - 1) / `QDR_CLK_PERIOD_NS)
// controller sequence steps
`define QDR_STEP_START 3'h0
`define QDR_STEP_ADDR_W 3'h1
`define QDR_STEP_CTRL 3'h2
`define QDR_STEP_ADDR_R 3'h3
`define QDR_STEP_READ0 3'h4
`define QDR_STEP_LAST2 3'h5
`define QDR_STEP_LAST3 3'h6
// controller register offsets (byte addresses)
`define QDR_REG_CTRL 4'h0
`define QDR_REG_STATUS 4'h4
`define QDR_REG_DATA 4'h8
// control register fields
`define QDR_CTRL_GO_BIT 0
`define QDR_CTRL_CH_LO_BIT 1
`define QDR_CTRL_CH_HI_BIT 2
`define QDR_CTRL_PD_BIT 3
`define QDR_CTRL_PIN_LO_BIT 4
`define QDR_CTRL_PIN_HI_BIT 5
`define QDR_CTRL_EXT_LO_BIT 6
`define QDR_CTRL_EXT_HI_BIT 7
// reset values
`define QDR_CODE_RESET 8'h00
`define QDR_MODE_RESET 2'h0
`endif

/* File: qdr_pkg.sv */
// types shared by both ends of the readback link
`default_nettype none
package qdr_pkg;

  typedef enum logic [1:0] {
    QDR_PD_HIZ = 2'h0,
    QDR_PD_1K = 2'h1,
    QDR_PD_100K = 2'h2,
    QDR_PD_HIZ_ALT = 2'h3
  } qdr_pd_mode_t;

  typedef enum logic [2:0] {
    QDR_D_IDLE = 3'h0,
    QDR_D_ADDR = 3'h1,
    QDR_D_ADDR_ACK = 3'h3,
    QDR_D_CTRL = 3'h2,
    QDR_D_CTRL_ACK = 3'h6,
    QDR_D_TX = 3'h7,
    QDR_D_TX_ACK = 3'h5,
    QDR_D_IGNORE = 3'h4
  } qdr_dev_state_t;

  typedef enum logic [1:0] {
    QDR_M_IDLE = 2'h0,
    QDR_M_START = 2'h1,
    QDR_M_XFER = 2'h3,
    QDR_M_STOP = 2'h2
  } qdr_mst_state_t;

  typedef struct packed {
    logic req;
    logic [1:0] ch;
    logic [7:0] code;
    logic [1:0] mode;
    logic ack_s1;
    logic ack_s2;
  } qdr_dev_user_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic req_s1;
    logic req_s2;
    logic req_d;
    qdr_dev_state_t state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] idx;
    logic [1:0] ch;
    logic pd_sel;
    logic ack_ok;
    logic sda_oe;
    logic [3:0][7:0] code;
    logic [3:0][1:0] mode;
  } qdr_dev_link_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [1:0] ch;
    logic pd;
    logic [1:0] pin;
    logic [1:0] ext;
    logic done;
    logic nack;
    logic [23:0] data;
    qdr_mst_state_t state;
    logic [1:0] q;
    logic [8:0] tick;
    logic [2:0] step;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack_bit;
    logic sda_s1;
    logic sda_s2;
    logic scl_low;
    logic sda_low;
  } qdr_mst_t;

endpackage
`default_nettype wire

/* File: qdr_link_if.sv */
// two-wire link between controller and converter, open-drain resolution
`timescale 1ns/100ps
`default_nettype none
interface qdr_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_d_out;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // pulled-up wires, low whenever an enabled driver pulls low
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

  modport master (output scl_out, output scl_oe, output sda_m_out, output sda_m_oe, input scl, input sda);
  modport device (output sda_d_out, output sda_d_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: qdr_device.sv */
// converter end: two-wire readback slave with channel code store
//
// Design decisions made here: the load port and its toggle handshake into the link clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "qdr_defines.svh"

module qdr_device
  import qdr_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic LINK_CLOCK_IN,
  input wire logic [1:0] PIN_ADDR_IN,
  input wire logic LOAD_IN,
  input wire logic [1:0] LOAD_CHANNEL_IN,
  input wire logic [7:0] LOAD_CODE_IN,
  input wire logic [1:0] LOAD_PD_MODE_IN,
  output logic LOAD_BUSY_OUT,
  qdr_link_if.device LINK
);

  qdr_dev_user_t u;
  qdr_dev_user_t next_u;
  qdr_dev_link_t l;
  qdr_dev_link_t next_l;
  logic [1:0] rst_sync;
  logic rst_link_n;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] first_byte;
  logic [7:0] next_byte;

  // -------------------------------------------------------------
  // byte selection
  // -------------------------------------------------------------
  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic pd, input logic [7:0] code,
                                         input logic [1:0] mode);
    logic [7:0] b;
    b = `QDR_LOW_FILL;
    if (pd)
    begin
      if (idx == 2'h0)
        b = {mode, `QDR_PD_FILL};
      else if (idx == 2'h1)
        b = code;
    end
    else if (idx == 2'h0)
      b = code;
    return b;
  endfunction

  function automatic logic [1:0] last_idx(input logic pd);
    return pd ? 2'h2 : 2'h1;
  endfunction

  // -------------------------------------------------------------
  // user side: load port, handshake into the link domain
  // -------------------------------------------------------------
  assign LOAD_BUSY_OUT = u.req ^ u.ack_s2;

  always_comb
  begin
    next_u = u;
    next_u.ack_s1 = l.req_d;
    next_u.ack_s2 = u.ack_s1;
    if (LOAD_IN && !LOAD_BUSY_OUT)
    begin
      next_u.req = ~u.req;
      next_u.ch = LOAD_CHANNEL_IN;
      next_u.code = LOAD_CODE_IN;
      next_u.mode = LOAD_PD_MODE_IN;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
      u <= '0;
    else
      u <= next_u;
  end

  // -------------------------------------------------------------
  // link side: reset synchroniser and line conditions
  // -------------------------------------------------------------
  always_ff @(posedge LINK_CLOCK_IN)
  begin
    rst_sync <= {rst_sync[0], RST_N_IN};
  end

  assign rst_link_n = rst_sync[1];
  assign scl_rise = l.scl_s2 & ~l.scl_d;
  assign scl_fall = ~l.scl_s2 & l.scl_d;
  assign start_seen = l.scl_s2 & l.scl_d & l.sda_d & ~l.sda_s2;
  assign stop_seen = l.scl_s2 & l.scl_d & ~l.sda_d & l.sda_s2;
  assign first_byte = tx_byte(2'h0, l.pd_sel, l.code[l.ch], l.mode[l.ch]);
  assign next_byte = tx_byte(2'(l.idx + 2'h1), l.pd_sel, l.code[l.ch], l.mode[l.ch]);

  assign LINK.sda_d_out = 1'b0;
  assign LINK.sda_d_oe = l.sda_oe;

  // -------------------------------------------------------------
  // link side: slave protocol engine
  // -------------------------------------------------------------
  always_comb
  begin
    next_l = l;
    next_l.scl_s1 = LINK.scl;
    next_l.scl_s2 = l.scl_s1;
    next_l.scl_d = l.scl_s2;
    next_l.sda_s1 = LINK.sda;
    next_l.sda_s2 = l.sda_s1;
    next_l.sda_d = l.sda_s2;
    next_l.pin_s1 = PIN_ADDR_IN;
    next_l.pin_s2 = l.pin_s1;
    next_l.req_s1 = u.req;
    next_l.req_s2 = l.req_s1;
    next_l.req_d = l.req_s2;
    if (l.req_s2 != l.req_d)
    begin
      next_l.code[u.ch] = u.code;
      next_l.mode[u.ch] = u.mode;
    end
    if (stop_seen)
    begin
      next_l.state = QDR_D_IDLE;
      next_l.sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      next_l.state = QDR_D_ADDR;
      next_l.cnt = 4'h0;
      next_l.sda_oe = 1'b0;
    end
    else
    begin
      unique case (l.state)
        QDR_D_IDLE, QDR_D_IGNORE:
        begin
          next_l.sda_oe = 1'b0;
        end
        QDR_D_ADDR, QDR_D_CTRL:
        begin
          if (scl_rise)
          begin
            next_l.sh = {l.sh[6:0], l.sda_s2};
            next_l.cnt = 4'(l.cnt + 4'h1);
          end
          else if (scl_fall && l.cnt == `QDR_ACK_SLOT)
          begin
            if (l.state == QDR_D_CTRL)
            begin
              next_l.ch = l.sh[2:1];
              next_l.pd_sel = l.sh[0];
              next_l.sda_oe = 1'b1;
              next_l.state = QDR_D_CTRL_ACK;
            end
            else if (l.sh[7:1] == {`QDR_SLAVE_BASE, l.pin_s2})
            begin
              next_l.sda_oe = 1'b1;
              next_l.state = QDR_D_ADDR_ACK;
            end
            else
              next_l.state = QDR_D_IGNORE;
          end
        end
        QDR_D_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_l.cnt = 4'h0;
            if (l.sh[0] == `QDR_DIR_READ)
            begin
              next_l.idx = 2'h0;
              next_l.sh = first_byte;
              next_l.sda_oe = ~first_byte[7];
              next_l.state = QDR_D_TX;
            end
            else
            begin
              next_l.sda_oe = 1'b0;
              next_l.state = QDR_D_CTRL;
            end
          end
        end
        QDR_D_CTRL_ACK:
        begin
          if (scl_fall)
          begin
            next_l.sda_oe = 1'b0;
            next_l.state = QDR_D_IGNORE;
          end
        end
        QDR_D_TX:
        begin
          if (scl_rise)
            next_l.cnt = 4'(l.cnt + 4'h1);
          else if (scl_fall)
          begin
            if (l.cnt == `QDR_ACK_SLOT)
            begin
              next_l.sda_oe = 1'b0;
              next_l.state = QDR_D_TX_ACK;
            end
            else
            begin
              next_l.sh = {l.sh[6:0], 1'b0};
              next_l.sda_oe = ~l.sh[6];
            end
          end
        end
        QDR_D_TX_ACK:
        begin
          if (scl_rise)
            next_l.ack_ok = ~l.sda_s2;
          else if (scl_fall)
          begin
            if (l.ack_ok && l.idx != last_idx(l.pd_sel))
            begin
              next_l.idx = 2'(l.idx + 2'h1);
              next_l.cnt = 4'h0;
              next_l.sh = next_byte;
              next_l.sda_oe = ~next_byte[7];
              next_l.state = QDR_D_TX;
            end
            else
            begin
              next_l.sda_oe = 1'b0;
              next_l.state = QDR_D_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLOCK_IN)
  begin
    if (!rst_link_n)
      l <= '0;
    else
      l <= next_l;
  end

endmodule
`default_nettype wire

/* File: qdr_master.sv */
// controller end: wishbone-driven two-wire readback master
`timescale 1ns/100ps
`default_nettype none
`include "qdr_defines.svh"
module qdr_master
  import qdr_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  qdr_link_if.master LINK
);

  qdr_mst_t m;
  qdr_mst_t next_m;
  logic wb_req;
  logic qend;
  logic is_rd;
  logic is_last;
  logic bit_low;

  // -------------------------------------------------------------
  // bytes sent by the controller
  // -------------------------------------------------------------
  function automatic logic [7:0] wr_byte(input logic [2:0] step, input qdr_mst_t s);
    logic [7:0] b;
    b = 8'hff;
    if (step == `QDR_STEP_ADDR_W)
      b = {`QDR_SLAVE_BASE, s.pin, `QDR_DIR_WRITE};
    else if (step == `QDR_STEP_CTRL)
      b = {s.ext, 2'h0, 1'b0, s.ch, s.pd};
    else if (step == `QDR_STEP_ADDR_R)
      b = {`QDR_SLAVE_BASE, s.pin, `QDR_DIR_READ};
    return b;
  endfunction

  assign wb_req = WB_CYC_IN & WB_STB_IN & ~m.ack;
  assign qend = m.tick == 9'(`QDR_SCL_QUARTER_CYCLES - 1);
  assign is_rd = m.step >= `QDR_STEP_READ0;
  assign is_last = m.step == (m.pd ? `QDR_STEP_LAST3 : `QDR_STEP_LAST2);
  assign bit_low = (m.cnt == `QDR_ACK_SLOT) ? (is_rd & ~is_last) : (~is_rd & ~m.sh[7]);
  assign WB_ACK_OUT = m.ack;
  assign WB_DAT_OUT = m.dat;
  assign LINK.scl_out = 1'b0;
  assign LINK.scl_oe = m.scl_low;
  assign LINK.sda_m_out = 1'b0;
  assign LINK.sda_m_oe = m.sda_low;

  // -------------------------------------------------------------
  // bus slave and bit engine
  // -------------------------------------------------------------
  always_comb
  begin
    next_m = m;
    next_m.sda_s1 = LINK.sda;
    next_m.sda_s2 = m.sda_s1;
    next_m.ack = wb_req;
    if (wb_req && !WB_WE_IN)
    begin
      unique case (WB_ADR_IN)
        `QDR_REG_CTRL: next_m.dat = {24'h0, m.ext, m.pin, m.pd, m.ch, 1'b0};
        `QDR_REG_STATUS: next_m.dat = {29'h0, m.nack, m.done, m.state != QDR_M_IDLE};
        `QDR_REG_DATA: next_m.dat = {8'h0, m.data};
        default: next_m.dat = 32'h0;
      endcase
    end
    else if (wb_req && WB_ADR_IN == `QDR_REG_CTRL && WB_SEL_IN[0] && m.state == QDR_M_IDLE)
    begin
      next_m.ch = WB_DAT_IN[`QDR_CTRL_CH_HI_BIT:`QDR_CTRL_CH_LO_BIT];
      next_m.pd = WB_DAT_IN[`QDR_CTRL_PD_BIT];
      next_m.pin = WB_DAT_IN[`QDR_CTRL_PIN_HI_BIT:`QDR_CTRL_PIN_LO_BIT];
      next_m.ext = WB_DAT_IN[`QDR_CTRL_EXT_HI_BIT:`QDR_CTRL_EXT_LO_BIT];
      if (WB_DAT_IN[`QDR_CTRL_GO_BIT])
      begin
        next_m.state = QDR_M_START;
        next_m.step = `QDR_STEP_START;
        next_m.q = 2'h0;
        next_m.tick = 9'h0;
        next_m.done = 1'b0;
        next_m.nack = 1'b0;
        next_m.data = 24'h0;
      end
    end
    if (m.state != QDR_M_IDLE)
    begin
      if (!qend)
        next_m.tick = 9'(m.tick + 9'h1);
      else
      begin
        next_m.tick = 9'h0;
        next_m.q = 2'(m.q + 2'h1);
        if (m.q == 2'h2 && m.state == QDR_M_XFER)
        begin
          next_m.ack_bit = m.sda_s2;
          if (is_rd && m.cnt != `QDR_ACK_SLOT)
            next_m.sh = {m.sh[6:0], m.sda_s2};
        end
        if (m.q == 2'h3)
        begin
          unique case (m.state)
            QDR_M_IDLE:
            begin
              next_m.state = QDR_M_IDLE;
            end
            QDR_M_START:
            begin
              next_m.state = QDR_M_XFER;
              next_m.step = 3'(m.step + 3'h1);
              next_m.cnt = 4'h0;
              next_m.sh = wr_byte(3'(m.step + 3'h1), m);
            end
            QDR_M_XFER:
            begin
              if (m.cnt != `QDR_ACK_SLOT)
              begin
                next_m.cnt = 4'(m.cnt + 4'h1);
                if (!is_rd)
                  next_m.sh = {m.sh[6:0], 1'b1};
              end
              else if (is_rd)
              begin
                next_m.data = {m.data[15:0], m.sh};
                next_m.cnt = 4'h0;
                next_m.step = 3'(m.step + 3'h1);
                if (is_last)
                  next_m.state = QDR_M_STOP;
              end
              else if (m.ack_bit)
              begin
                next_m.nack = 1'b1;
                next_m.state = QDR_M_STOP;
              end
              else if (m.step == `QDR_STEP_CTRL)
                next_m.state = QDR_M_START;
              else
              begin
                next_m.step = 3'(m.step + 3'h1);
                next_m.cnt = 4'h0;
                next_m.sh = wr_byte(3'(m.step + 3'h1), m);
              end
            end
            QDR_M_STOP:
            begin
              next_m.state = QDR_M_IDLE;
              next_m.done = 1'b1;
            end
          endcase
        end
      end
    end
    unique case (m.state)
      QDR_M_IDLE:
      begin
        next_m.scl_low = 1'b0;
        next_m.sda_low = 1'b0;
      end
      QDR_M_START:
      begin
        next_m.scl_low = m.q == 2'h0 || m.q == 2'h3;
        next_m.sda_low = m.q[1];
      end
      QDR_M_XFER:
      begin
        next_m.scl_low = ~m.q[1];
        if (m.q == 2'h1)
          next_m.sda_low = bit_low;
      end
      QDR_M_STOP:
      begin
        next_m.scl_low = ~m.q[1];
        if (m.q != 2'h0)
          next_m.sda_low = m.q != 2'h3;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
      m <= '0;
    else
      m <= next_m;
  end

endmodule
`default_nettype wire

/* File: qdr_assertions.sv */
// checker of the two-wire link between controller and converter
`timescale 1ns/100ps
`default_nettype none
`include "qdr_defines.svh"
module qdr_assertions
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [1:0] PIN_ADDR_IN,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_d_oe
);
  // ----------------
  // bus decoding
  // ----------------
  logic scl_d, sda_d, ctl_ok, end_rd, rise, start, stop, hit, rd;
  logic [3:0] bit_no;
  logic [2:0] byte_no;
  logic [2:0] last;
  logic [7:0] sh, adr, ctl;
  logic [11:0] wait_cnt;
  assign rise = scl & ~scl_d;
  assign start = scl & scl_d & sda_d & ~sda;
  assign stop = scl & scl_d & ~sda_d & sda;
  assign hit = adr[7:1] == {`QDR_SLAVE_BASE, PIN_ADDR_IN};
  assign rd = hit & adr[0];
  assign last = ctl[0] ? 3'h3 : 3'h2;
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bit_no <= 4'h0;
      byte_no <= 3'h0;
      sh <= 8'h00;
      adr <= 8'h00;
      ctl <= 8'h00;
      ctl_ok <= 1'b0;
      end_rd <= 1'b0;
      wait_cnt <= 12'h000;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
      wait_cnt <= end_rd ? wait_cnt + 12'h001 : 12'h000;
      if (start | stop)
      begin
        bit_no <= 4'h0;
        byte_no <= 3'h0;
        end_rd <= 1'b0;
        ctl_ok <= ctl_ok & start;
      end
      else if (rise)
      begin
        sh <= {sh[6:0], sda};
        bit_no <= (bit_no == 4'h8) ? 4'h0 : bit_no + 4'h1;
        if (bit_no == 4'h8 && byte_no != 3'h7)
          byte_no <= byte_no + 3'h1;
        if (bit_no == 4'h7 && byte_no == 3'h0)
          adr <= {sh[6:0], sda};
        if (bit_no == 4'h7 && byte_no == 3'h1 && hit && !adr[0])
          ctl <= {sh[6:0], sda};
        if (bit_no == 4'h8 && byte_no == 3'h1 && hit && !adr[0] && !sda)
          ctl_ok <= 1'b1;
        if (bit_no == 4'h8 && rd && byte_no == last)
          end_rd <= 1'b1;
      end
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  property p_addr_ack;
    rise && bit_no == 4'h8 && byte_no == 3'h0 && hit |-> !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address not acknowledged");
  property p_ctrl_ack;
    rise && bit_no == 4'h8 && byte_no == 3'h1 && hit && !adr[0] |-> !sda;
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack)
    else $error("control byte not acknowledged");
  property p_rd_after_ctrl;
    rise && bit_no == 4'h8 && byte_no == 3'h0 && rd |-> ctl_ok;
  endproperty
  a_rd_after_ctrl: assert property (p_rd_after_ctrl)
    else $error("read address without control byte");
  property p_dev_edge;
    $changed(sda_d_oe) |-> !scl;
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("device changed data while clock high");
  property p_mst_off;
    rise && rd && byte_no != 3'h0 && byte_no <= last && bit_no != 4'h8 |-> !sda_m_oe;
  endproperty
  a_mst_off: assert property (p_mst_off)
    else $error("controller drives during read bits");
  property p_pd_fill;
    rise && rd && ctl[0] && byte_no == 3'h1 && bit_no >= 4'h2 && bit_no <= 4'h7 |-> sda;
  endproperty
  a_pd_fill: assert property (p_pd_fill)
    else $error("status byte fill bit low");
  property p_mst_ack;
    rise && rd && bit_no == 4'h8 && byte_no != 3'h0 && byte_no <= last |-> sda == (byte_no == last);
  endproperty
  a_mst_ack: assert property (p_mst_ack)
    else $error("wrong acknowledge on read byte");
  property p_end_stop;
    wait_cnt < 12'h7d0;
  endproperty
  a_end_stop: assert property (p_end_stop)
    else $error("no stop after end of read");
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench: controller and converter joined over the link
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, link_clk, rst_n, dev_rst_n, cyc, stb, we, ack, load, busy;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0] lch, lmode;
  logic [7:0] lcode;
  int n_errors, samples_checked;
  localparam logic [1:0] DEV_PIN = 2'h2;
  qdr_link_if lnk ();
  qdr_master qdr_master_i (.CLOCK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .LINK(lnk));
  qdr_device qdr_device_i (.CLOCK_IN(clk), .RST_N_IN(dev_rst_n), .LINK_CLOCK_IN(link_clk),
    .PIN_ADDR_IN(DEV_PIN), .LOAD_IN(load), .LOAD_CHANNEL_IN(lch), .LOAD_CODE_IN(lcode),
    .LOAD_PD_MODE_IN(lmode), .LOAD_BUSY_OUT(busy), .LINK(lnk));
  qdr_assertions qdr_assertions_i (.CLOCK_IN(clk), .RST_N_IN(dev_rst_n), .PIN_ADDR_IN(DEV_PIN),
    .scl(lnk.scl), .sda(lnk.sda), .sda_m_oe(lnk.sda_m_oe), .sda_d_oe(lnk.sda_d_oe));
  // ----------------
  // clocks
  // ----------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.1;
    forever #62.5 link_clk = ~link_clk;
  end
  // ----------------
  // tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("CHECK FAILED at %0t: %s %h/%h", $time, m, seen, exp);
      end
    end
  endtask
  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
        @(posedge clk);
      end
      while (ack !== 1'b1);
      q = rdat;
      check({31'h0, ack}, 32'h1, "bus ack");
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task automatic ld(input logic [1:0] c, input logic [7:0] v, input logic [1:0] m);
    int n;
    begin
      n = 0;
      @(posedge clk);
      load <= 1'b1;
      lch <= c;
      lcode <= v;
      lmode <= m;
      @(posedge clk);
      load <= 1'b0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (busy !== 1'b0 && n < 100);
      check({31'h0, busy}, 32'h0, "load");
    end
  endtask
  task automatic rd_ch(input logic [1:0] c, input logic pd, input logic [1:0] pin,
    input logic [31:0] st, input logic [31:0] dat, input string m);
    int n;
    begin
      n = 0;
      wb(1'b1, 4'h0, {24'h0, 2'h0, pin, pd, c, 1'b1});
      wb(1'b0, 4'h4, 32'h0);
      check(q, 32'h1, m);
      wb(1'b1, 4'h0, {24'h0, 2'h3, ~pin, ~pd, ~c, 1'b1});
      do
      begin
        repeat (100) @(posedge clk);
        wb(1'b0, 4'h4, 32'h0);
        n++;
      end
      while (q[1] !== 1'b1 && n < 2000);
      check(q, st, m);
      wb(1'b0, 4'h0, 32'h0);
      check(q, {24'h0, 2'h0, pin, pd, c, 1'b0}, m);
      wb(1'b0, 4'h8, 32'h0);
      check(q & 32'hffffff00, dat, m);
      $display("test %s done", m);
    end
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    rst_n = 1'b0;
    dev_rst_n = 1'b0;
    {cyc, stb, we, load} = 4'h0;
    adr = 4'h0;
    wdat = 32'h0;
    {lch, lcode, lmode} = 12'h000;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    dev_rst_n <= 1'b1;
    repeat (60) @(posedge clk);
    check({30'h0, lnk.scl, lnk.sda}, 32'h3, "idle");
    for (int a = 0; a < 16; a += 4)
    begin
      wb(1'b1, a[3:0], 32'hffffff00);
      wb(1'b0, a[3:0], 32'h0);
      check(q, 32'h0, "reset value");
    end
    $display("test registers done");
    ld(2'h0, 8'h11, 2'h1);
    ld(2'h1, 8'h5a, 2'h3);
    ld(2'h3, 8'ha5, 2'h2);
    rd_ch(2'h1, 1'b0, 2'h1, 32'h6, 32'h0, "wrong pin");
    rd_ch(2'h3, 1'b1, DEV_PIN, 32'h2, 32'h00bfa500, "status read");
    rd_ch(2'h2, 1'b0, DEV_PIN, 32'h2, 32'h0, "plain read");
    rd_ch(2'h0, 1'b0, DEV_PIN, 32'h2, 32'h00001100, "loaded plain read");
    rd_ch(2'h1, 1'b1, DEV_PIN, 32'h2, 32'h00ff5a00, "second status read");
    close_out;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    close_out;
  end
endmodule
`default_nettype wire
